// ---- logic/capture_pkg.sv ----
`default_nettype none
package capture_pkg;
  // register word offsets (byte addresses on the register bus)
  localparam logic [7:0] UNIT1_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] UNIT1_VALUE_OFS    = 8'h04;
  localparam logic [7:0] UNIT2_CONTROL_OFS  = 8'h08;
  localparam logic [7:0] UNIT2_VALUE_OFS    = 8'h0C;
  localparam logic [7:0] TIMER_SELECT_OFS   = 8'h10;
  localparam logic [7:0] FLAGS_OFS          = 8'h14;
  localparam logic [7:0] PIN_CONFIG_OFS     = 8'h18;

  // field positions
  localparam int MODE_LSB      = 0;
  localparam int DUTY_LSB      = 4;
  localparam int SEL_UNIT1_BIT = 3;   // in third_timer_control
  localparam int SEL_UNIT2_BIT = 6;   // in third_timer_control
  localparam int FLAG1_BIT     = 0;
  localparam int FLAG2_BIT     = 1;
  localparam int ROUTE_BIT     = 0;
  localparam int DIR_C1_BIT    = 1;
  localparam int DIR_B3_BIT    = 2;
  localparam int LATCH_C1_BIT  = 3;
  localparam int LATCH_B3_BIT  = 4;

  // reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] T3CTL_RST    = 8'h00;
  localparam logic       ROUTE_RST    = 1'b1;
  localparam logic [3:0] PRESCALE_RST = 4'h0;

  // prescale terminal counts
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hF;

  typedef enum logic [3:0] {
    MODE_OFF      = 4'b0000,
    MODE_FALL     = 4'b0100,
    MODE_RISE     = 4'b0101,
    MODE_RISE4    = 4'b0110,
    MODE_RISE16   = 4'b0111
  } mode_e;

  // timer resource picked for one unit
  typedef enum logic [1:0] {
    BASE_FIRST  = 2'b00,
    BASE_THIRD  = 2'b01,
    BASE_SECOND = 2'b10
  } base_e;

  typedef struct packed {
    logic [15:0] first_timer_count;
    logic [15:0] second_timer_count;
    logic [15:0] third_timer_count;
  } timers_s;
endpackage
`default_nettype wire

// ---- logic/edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ==========================================================
  // two-stage synchroniser, edges seen only past stage two
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // one pulse per edge of the synchronised level
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule // edge_sync
`default_nettype wire

// ---- logic/capture_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module capture_unit
  import capture_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  mode_i,
  input  wire logic        rise_i,
  input  wire logic        fall_i,
  input  wire logic [15:0] base_count_i,
  input  wire logic        wr_low_i,
  input  wire logic        wr_high_i,
  input  wire logic [7:0]  wr_data_i,
  output logic [15:0]      value_o,
  output logic             capture_o
);
  logic [3:0]  presc_q;
  logic [15:0] value_q;
  logic        is_capture;
  logic        qualify;

  // ==========================================================
  // capture modes are the 01xx codes
  assign is_capture = (mode_i[3:2] == 2'b01);

  // event qualification per mode
  always_comb
  begin
    qualify = 1'b0;
    unique case (mode_i)
      MODE_FALL:   qualify = fall_i;
      MODE_RISE:   qualify = rise_i;
      MODE_RISE4:  qualify = rise_i && ((presc_q & DIV4_LAST) == DIV4_LAST);
      MODE_RISE16: qualify = rise_i && (presc_q == DIV16_LAST);
      default:     qualify = 1'b0;
    endcase
  end

  // prescaler cleared off capture mode only; switching divisors keeps it
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !is_capture)
      presc_q <= PRESCALE_RST;
    else if (rise_i)
      presc_q <= 4'(presc_q + 4'h1);
  end

  // latest capture overwrites, software may also load either half
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      value_q <= 16'h0000;
    else if (is_capture && qualify)
      value_q <= base_count_i;
    else
    begin
      if (wr_low_i)
        value_q[7:0] <= wr_data_i;
      if (wr_high_i)
        value_q[15:8] <= wr_data_i;
    end
  end

  assign value_o   = value_q;
  assign capture_o = is_capture && qualify;
endmodule // capture_unit
`default_nettype wire

// ---- logic/timer_capture_unit.sv ----
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_unit
  import capture_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire capture_pkg::timers_s timers_i,
  input  wire logic                portc_bit1_pin_i,
  input  wire logic                portb_bit3_pin_i,
  input  wire logic                second_unit_pin_route_i,
  output logic                     portc_bit1_pin_o,
  output logic                     portc_bit1_pin_oe_o,
  output logic                     portb_bit3_pin_o,
  output logic                     portb_bit3_pin_oe_o,
  output logic [1:0]               unit_event_flag_o,
  output logic [1:0]               base_select_o,
  output logic [1:0]               conversion_start_o
);
  import capture_pkg::*;

  logic [7:0]  unit1_control_q;
  logic [7:0]  unit2_control_q;
  logic [7:0]  third_timer_control_q;
  logic [1:0]  unit_event_flag_q;
  logic [1:0]  unit_event_enable_q;
  logic [1:0]  pin_direction_bits_q;    // 1 = input
  logic [1:0]  port_latch_q;
  logic        route_q;
  logic        route_seen_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [1:0]  base_select_q;
  logic [1:0]  conv_q;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [15:0] value1;
  logic [15:0] value2;
  logic [1:0]  cap;
  logic        rise1;
  logic        fall1;
  logic        rise2;
  logic        fall2;
  logic        pin1_level;
  logic        pin2_level;
  logic [15:0] base1;
  logic [15:0] base2;

  // ==========================================================
  // apb slave: access phase with one wait state, pready raised at its first edge
  assign wr = psel && penable && pwrite && !pready_q;
  assign rd = psel && penable && !pwrite && !pready_q;

  always_comb
  begin
    hit = 1'b1;
    unique case (paddr)
      UNIT1_CONTROL_OFS, UNIT1_VALUE_OFS, UNIT2_CONTROL_OFS, UNIT2_VALUE_OFS,
      TIMER_SELECT_OFS, FLAGS_OFS, PIN_CONFIG_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // pready pulses for one cycle; unmapped address gets pslverr
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      if (rd)
      begin
        unique case (paddr)
          UNIT1_CONTROL_OFS: prdata_q <= {24'h000000, 2'b00, unit1_control_q[5:0]};
          UNIT1_VALUE_OFS:   prdata_q <= {16'h0000, value1};
          UNIT2_CONTROL_OFS: prdata_q <= {24'h000000, 2'b00, unit2_control_q[5:0]};
          UNIT2_VALUE_OFS:   prdata_q <= {16'h0000, value2};
          TIMER_SELECT_OFS:  prdata_q <= {24'h000000, third_timer_control_q};
          FLAGS_OFS:         prdata_q <= {28'h0000000, unit_event_enable_q, unit_event_flag_q};
          PIN_CONFIG_OFS:    prdata_q <= {27'h0000000, port_latch_q, pin_direction_bits_q,
                                          route_q};
          default:           prdata_q <= 32'h0000_0000;
        endcase
      end
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // control registers; low byte lane only
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      unit1_control_q       <= CONTROL_RST;
      unit2_control_q       <= CONTROL_RST;
      third_timer_control_q <= T3CTL_RST;
      unit_event_enable_q   <= 2'b00;
      pin_direction_bits_q  <= 2'b11;
      port_latch_q          <= 2'b00;
    end
    else if (wr && pstrb[0])
    begin
      if (paddr == UNIT1_CONTROL_OFS)
        unit1_control_q <= pwdata[7:0];
      if (paddr == UNIT2_CONTROL_OFS)
        unit2_control_q <= pwdata[7:0];
      if (paddr == TIMER_SELECT_OFS)
        third_timer_control_q <= pwdata[7:0];
      if (paddr == FLAGS_OFS)
        unit_event_enable_q <= pwdata[3:2];
      if (paddr == PIN_CONFIG_OFS)
      begin
        pin_direction_bits_q <= pwdata[DIR_B3_BIT:DIR_C1_BIT];
        port_latch_q         <= pwdata[LATCH_B3_BIT:LATCH_C1_BIT];
      end
    end
  end

  // route strap caught in the first cycle after reset release
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      route_q      <= ROUTE_RST;
      route_seen_q <= 1'b0;
    end
    else if (!route_seen_q)
    begin
      route_q      <= second_unit_pin_route_i;
      route_seen_q <= 1'b1;
    end
  end

  // ==========================================================
  // timer assignment: capture class takes first or third timer
  function automatic logic [1:0] pick(input logic [3:0] mode, input logic sel);
    if (mode[3:2] == 2'b11)
      pick = BASE_SECOND;
    else
      pick = sel ? BASE_THIRD : BASE_FIRST;
  endfunction

  // resolved resource per unit; a function result cannot be bit-selected directly
  logic [1:0]  pick1;
  logic [1:0]  pick2;
  assign pick1 = pick(unit1_control_q[3:0], third_timer_control_q[SEL_UNIT1_BIT]);
  assign pick2 = pick(unit2_control_q[3:0], third_timer_control_q[SEL_UNIT2_BIT]);

  assign base1 = third_timer_control_q[SEL_UNIT1_BIT] ? timers_i.third_timer_count
                                                      : timers_i.first_timer_count;
  assign base2 = third_timer_control_q[SEL_UNIT2_BIT] ? timers_i.third_timer_count
                                                      : timers_i.first_timer_count;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      base_select_q <= 2'b00;
      conv_q        <= 2'b00;
    end
    else
    begin
      base_select_q <= {pick2 == BASE_THIRD, pick1 == BASE_THIRD};
      // conversion start is never raised; the second unit's trigger is masked to zero
      conv_q        <= {cap[1] & 1'b0, 1'b0};
    end
  end

  assign base_select_o      = base_select_q;
  assign conversion_start_o = conv_q;

  // ==========================================================
  // pin levels: driven pins read back their own latch
  assign pin1_level = pin_direction_bits_q[0] ? portc_bit1_pin_i : port_latch_q[0];
  assign pin2_level = route_q
                    ? (pin_direction_bits_q[0] ? portc_bit1_pin_i : port_latch_q[0])
                    : (pin_direction_bits_q[1] ? portb_bit3_pin_i : port_latch_q[1]);

  edge_sync u_sync1
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (pin1_level),
    .rise_o  (rise1),
    .fall_o  (fall1)
  );

  edge_sync u_sync2
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (pin2_level),
    .rise_o  (rise2),
    .fall_o  (fall2)
  );

  capture_unit u_first
  (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .mode_i       (unit1_control_q[3:0]),
    .rise_i       (rise1),
    .fall_i       (fall1),
    .base_count_i (base1),
    .wr_low_i     (wr && pstrb[0] && paddr == UNIT1_VALUE_OFS),
    .wr_high_i    (wr && pstrb[1] && paddr == UNIT1_VALUE_OFS),
    .wr_data_i    (pstrb[0] ? pwdata[7:0] : pwdata[15:8]),
    .value_o      (value1),
    .capture_o    (cap[0])
  );

  capture_unit u_second
  (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .mode_i       (unit2_control_q[3:0]),
    .rise_i       (rise2),
    .fall_i       (fall2),
    .base_count_i (base2),
    .wr_low_i     (wr && pstrb[0] && paddr == UNIT2_VALUE_OFS),
    .wr_high_i    (wr && pstrb[1] && paddr == UNIT2_VALUE_OFS),
    .wr_data_i    (pstrb[0] ? pwdata[7:0] : pwdata[15:8]),
    .value_o      (value2),
    .capture_o    (cap[1])
  );

  // ==========================================================
  // sticky flags: capture wins over a clearing write in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      unit_event_flag_q <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cap[i])
          unit_event_flag_q[i] <= 1'b1;
        else if (wr && pstrb[0] && paddr == FLAGS_OFS && !pwdata[i])
          unit_event_flag_q[i] <= 1'b0;
      end
    end
  end

  assign unit_event_flag_o = unit_event_flag_q;

  // ==========================================================
  // pin drivers: latch drives when direction bit says output
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      portc_bit1_pin_o    <= 1'b0;
      portc_bit1_pin_oe_o <= 1'b0;
      portb_bit3_pin_o    <= 1'b0;
      portb_bit3_pin_oe_o <= 1'b0;
    end
    else
    begin
      portc_bit1_pin_o    <= port_latch_q[0];
      portc_bit1_pin_oe_o <= !pin_direction_bits_q[0];
      portb_bit3_pin_o    <= port_latch_q[1];
      portb_bit3_pin_oe_o <= !pin_direction_bits_q[1];
    end
  end
endmodule // timer_capture_unit
`default_nettype wire

// ---- tb/event_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far-side event source on the capture pin
module event_source
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [4:0] count_i,
  input  wire logic       level_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic [4:0] left_q;
  logic [2:0] phase_q;

  // pulses are 4 high then 4 low, slow enough for the pin synchroniser
  always_ff @(posedge clock_i)
  begin
    if (rst_i || start_i)
    begin
      left_q  <= rst_i ? 5'h00 : count_i;
      phase_q <= 3'h0;
    end
    else if (left_q != 5'h00)
    begin
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7)
        left_q <= left_q - 5'h01;
    end
  end

  // only ever drives an input pin, the unit never drives it back
  assign busy_o = (left_q != 5'h00);
  assign pin_o  = busy_o ? !phase_q[2] : level_i;
endmodule // event_source
`default_nettype wire

// ---- tb/timer_capture_unit_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module timer_capture_unit_asserts
  import capture_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        portc_bit1_pin_i,
  input wire logic        portb_bit3_pin_i,
  input wire logic        second_unit_pin_route_i,
  input wire logic [1:0]  unit_event_flag_o,
  input wire logic [1:0]  base_select_o,
  input wire logic [1:0]  conversion_start_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic       pin_sel;
  logic       prev_q;
  logic [3:0] since_q;

  // cycles since the routed pin last moved, saturating
  assign pin_sel = second_unit_pin_route_i ? portc_bit1_pin_i : portb_bit3_pin_i;
  always_ff @(posedge clock_i)
  begin
    prev_q <= pin_sel;
    if (rst_i)
      since_q <= 4'hF;
    else if (pin_sel != prev_q)
      since_q <= 4'h1;
    else if (since_q != 4'hF)
      since_q <= since_q + 4'h1;
  end

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_flag_sticky: assert property ($fell(unit_event_flag_o[1]) |->
    $past(psel && pwrite && paddr == FLAGS_OFS)) else $error("flag cleared by hardware");
  a_base_by_write: assert property ($changed(base_select_o) |->
    $past(psel && pwrite && paddr == TIMER_SELECT_OFS)) else $error("base moved");
  a_no_convert: assert property (conversion_start_o == 2'h0)
    else $error("conversion start");
  a_capture_edge: assert property ($rose(unit_event_flag_o[1]) |->
    since_q >= 4'h1 && since_q <= 4'h6) else $error("capture without pin edge");
endmodule // timer_capture_unit_asserts

bind timer_capture_unit timer_capture_unit_asserts chk_u (.clock_i, .rst_i, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .portc_bit1_pin_i, .portb_bit3_pin_i,
  .second_unit_pin_route_i, .unit_event_flag_o, .base_select_o, .conversion_start_o);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// self-checking bench
module testbench;
  import capture_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr, src_pin, busy, c1_o, c1_oe, b3_o, b3_oe;
  timers_s     timers  = '0;
  logic        start   = 1'b0;
  logic [4:0]  count   = 5'h01;
  logic        level   = 1'b0;
  logic        route_strap = 1'b1;
  logic [1:0]  flags, base_sel, conv;
  int          miscompares = 0;
  int          n_tests     = 0;

  always #5 clock_i = ~clock_i;
  // port b has nobody else on it here, so it idles low
  wire c1_pin = c1_oe ? c1_o : src_pin;
  wire b3_pin = b3_oe ? b3_o : 1'b0;

  timer_capture_unit dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timers_i(timers),
    .portc_bit1_pin_i(c1_pin), .portb_bit3_pin_i(b3_pin),
    .second_unit_pin_route_i(route_strap),
    .portc_bit1_pin_o(c1_o), .portc_bit1_pin_oe_o(c1_oe), .portb_bit3_pin_o(b3_o),
    .portb_bit3_pin_oe_o(b3_oe), .unit_event_flag_o(flags), .base_select_o(base_sel),
    .conversion_start_o(conv));
  event_source src_u (.clock_i(clock_i), .rst_i(rst_i), .start_i(start), .count_i(count),
    .level_i(level), .pin_o(src_pin), .busy_o(busy));

  task automatic final_report();
    $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the wait for pready is bounded, never assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdata, exp);
  endtask

  // settle time covers the 3-cycle pin-to-flag latency
  task automatic set_level(input logic v);
    level <= v;
    repeat (8) @(posedge clock_i);
  endtask

  task automatic pulses(input logic [4:0] n);
    int k;
    count <= n;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while ((busy || k < 2) && k < 200);
    if (k >= 200)
    begin
      miscompares++;
      final_report();
    end
    repeat (8) @(posedge clock_i);
  endtask

  task automatic t_reset();
    rd(UNIT2_CONTROL_OFS, 32'h0);
    rd(UNIT2_VALUE_OFS, 32'h0);
    rd(FLAGS_OFS, 32'h0);
    rd(PIN_CONFIG_OFS, 32'h7);
  endtask

  task automatic t_regs();
    apb(1'b1, UNIT2_VALUE_OFS, 32'hA5, 4'h1);
    // the high half travels on byte lane one
    apb(1'b1, UNIT2_VALUE_OFS, 32'h3C00, 4'h2);
    rd(UNIT2_VALUE_OFS, 32'h3CA5);
    apb(1'b1, UNIT1_CONTROL_OFS, 32'h36, 4'h1);
    rd(UNIT1_CONTROL_OFS, 32'h36);
    apb(1'b1, UNIT1_CONTROL_OFS, 32'h0, 4'h1);
    apb(1'b0, 8'h1C, 32'h0, 4'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, TIMER_SELECT_OFS, 32'h48, 4'h1);
    @(posedge clock_i);
    chk(32'(base_sel), 32'h3);
    apb(1'b1, TIMER_SELECT_OFS, 32'h40, 4'h1);
    @(posedge clock_i);
    chk(32'(base_sel), 32'h2);
  endtask

  task automatic t_rise();
    timers.first_timer_count <= 16'hAAAA;
    timers.third_timer_count <= 16'h1234;
    apb(1'b1, UNIT2_CONTROL_OFS, 32'h5, 4'h1);
    set_level(1'b1);
    chk(32'(flags[1]), 32'h1);
    apb(1'b1, FLAGS_OFS, 32'h0, 4'h1);
    timers.third_timer_count <= 16'h5678;
    set_level(1'b0);
    chk(32'(flags[1]), 32'h0);
    timers.third_timer_count <= 16'h9ABC;
    set_level(1'b1);
    rd(UNIT2_VALUE_OFS, 32'h9ABC);
    rd(FLAGS_OFS, 32'h2);
  endtask

  task automatic t_fall();
    apb(1'b1, FLAGS_OFS, 32'h0, 4'h1);
    apb(1'b1, UNIT2_CONTROL_OFS, 32'h4, 4'h1);
    timers.third_timer_count <= 16'h0F0F;
    set_level(1'b0);
    timers.third_timer_count <= 16'h1111;
    set_level(1'b1);
    rd(UNIT2_VALUE_OFS, 32'h0F0F);
    rd(FLAGS_OFS, 32'h2);
  endtask

  // turning the unit off between settings must restart the edge count
  task automatic t_prescale();
    mode_e      m[2];
    logic [4:0] n;
    m[0] = MODE_RISE4;
    m[1] = MODE_RISE16;
    for (int i = 0; i < 2; i++)
    begin
      n = (i == 0) ? 5'h04 : 5'h10;
      apb(1'b1, UNIT2_CONTROL_OFS, {28'h0, MODE_OFF}, 4'h1);
      set_level(1'b0);
      apb(1'b1, UNIT2_CONTROL_OFS, {28'h0, m[i]}, 4'h1);
      // enables stay clear and the flag is cleared after the mode change
      apb(1'b1, FLAGS_OFS, 32'h0, 4'h1);
      pulses(n - 5'h01);
      chk(32'(flags[1]), 32'h0);
      pulses(5'h01);
      chk(32'(flags[1]), 32'h1);
    end
  endtask

  // strap moves only under a mid-run reset; unit two then listens on port b,
  // where a latch write on the driven pin is the capture event
  task automatic t_route();
    route_strap <= 1'b0;
    rst_i       <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(PIN_CONFIG_OFS, 32'h6);
    apb(1'b1, UNIT2_CONTROL_OFS, 32'h5, 4'h1);
    apb(1'b1, PIN_CONFIG_OFS, 32'h12, 4'h1);
    repeat (8) @(posedge clock_i);
    chk(32'({b3_oe, b3_o, c1_oe, c1_o}), 32'hC);
    rd(FLAGS_OFS, 32'h2);
    rd(UNIT2_VALUE_OFS, 32'hAAAA);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_rise();
    t_fall();
    t_prescale();
    t_route();
    final_report();
  end
endmodule // testbench
`default_nettype wire
